// file: include/cfb_pkg.sv
// Function
// R1 - Mode high runs the pair bank and its feedback; low runs the single bank.
// R2 - One reference fans out to six pairs or thirteen singles, never both.
// R3 - Pair true outputs follow the reference; complements are its inverse.
// R4 - A cleared enable bit in the three enable bytes holds its output low.
// R5 - Feedback outputs ignore enable bits and run whenever their bank is selected.
// R6 - All serial registers load defaults at reset, so no access is needed.
// R7 - Serial data is sampled on the serial clock and shifted into enable registers.
// R8 - The selected feedback output is a non-inverted in-phase copy of the reference.
// R9 - The host may write enables at start-up or later; access is optional.
// R10 - Only slave address 11010010 is answered; the host always uses it.
// R11 - Command bit 7 set means indexed byte access at bits 6:0; clear means block.
// R12 - Block transfers run ascending from byte zero, MSB first, stoppable per byte.
// R13 - Every enable bit defaults to one, so all selected outputs run after reset.
package cfb_pkg;

  // ==========================================================================
  // Fan-out shape
  localparam int CFB_PAIR_COUNT = 6;
  localparam int CFB_SINGLE_COUNT = 13;
  localparam int CFB_ENABLE_BYTES = 3;
  localparam logic [7:0] CFB_ENABLE_RESET = 8'hFF;
  localparam int CFB_PAIR_BYTE = 0;
  localparam int CFB_SINGLE_LO_BYTE = 1;
  localparam int CFB_SINGLE_HI_BYTE = 2;
  localparam int CFB_SINGLE_LO_COUNT = 8;
  localparam logic MODE_PAIR_BANK = 1'b1;

  // ==========================================================================
  // Serial port
  localparam logic [7:0] CFB_SLAVE_ADDR = 8'hD2;
  localparam int CFB_CMD_BYTE_MODE_BIT = 7;
  localparam logic [3:0] CFB_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] CFB_LAST_BIT = 4'h7;
  localparam logic [6:0] CFB_FIRST_OFFSET = 7'h00;
  localparam logic [7:0] CFB_BLOCK_COUNT = 8'h03;
  localparam logic [6:0] CFB_OFFSET_LIMIT = 7'h03;

  typedef enum logic [3:0] {
    LINK_IDLE,
    LINK_ADDR,
    LINK_ADDR_ACK,
    LINK_CMD,
    LINK_CMD_ACK,
    LINK_COUNT,
    LINK_COUNT_ACK,
    LINK_WDATA,
    LINK_WDATA_ACK,
    LINK_TX,
    LINK_TX_ACK,
    LINK_SKIP
  } cfb_link_state_e;

  // ==========================================================================
  // APB register map
  localparam logic [7:0] CFB_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] CFB_STATUS_OFFSET = 8'h04;
  localparam logic [7:0] CFB_ENABLES_OFFSET = 8'h08;
  localparam int CFB_CTRL_PORT_EN_BIT = 0;
  localparam logic CFB_CTRL_PORT_EN_RESET = 1'b1;
  localparam int CFB_STATUS_MODE_BIT = 0;

endpackage

// file: design/cfb_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Two-flop level synchroniser
module cfb_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

`default_nettype wire

// file: design/cfb_clock_fanout.sv
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none

module cfb_clock_fanout
  import cfb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_clk,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  input wire logic bank_mode_select,
  input wire logic reference_clock_in,
  output logic [CFB_PAIR_COUNT-1:0] pair_true_outputs,
  output logic [CFB_PAIR_COUNT-1:0] pair_complement_outputs,
  output logic [CFB_SINGLE_COUNT-1:0] single_outputs,
  output logic pair_feedback_out,
  output logic single_feedback_out
);

  // ==========================================================================
  // Link domain reset: asserted with presetn, released on link_clk
  logic link_rst_meta;
  logic link_rst_n;

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      link_rst_meta <= 1'b0;
      link_rst_n <= 1'b0;
    end else begin
      link_rst_meta <= 1'b1;
      link_rst_n <= link_rst_meta;
    end
  end

  // ==========================================================================
  // Serial pin sampling and bus condition detection
  logic [1:0] pins_sync;
  logic scl;
  logic sda;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic port_en_link;
  logic port_en;

  // Inverted through the synchroniser so its reset level matches the idle-high bus
  cfb_sync #(.WIDTH(2)) u_pin_sync (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .d(~{serial_clock_in, serial_data_in}),
    .q(pins_sync)
  );

  assign scl = ~pins_sync[1];
  assign sda = ~pins_sync[0];

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  assign scl_rise = scl & ~scl_d;
  assign scl_fall = ~scl & scl_d;
  assign bus_start = scl & scl_d & sda_d & ~sda;
  assign bus_stop = scl & scl_d & ~sda_d & sda;

  cfb_sync #(.WIDTH(1)) u_port_en_sync (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .d(port_en),
    .q(port_en_link)
  );

  // ==========================================================================
  // Serial slave state machine
  cfb_link_state_e state;
  logic [3:0] bit_count;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic [7:0] next_tx_byte;
  logic [6:0] byte_ptr;
  logic read_dir;
  logic byte_mode;
  logic count_pending;
  logic master_ack;
  logic sda_drive;
  logic byte_done;
  logic write_strobe;
  logic [7:0] enable_reg [CFB_ENABLE_BYTES];
  logic [7:0] rx_byte;
  logic [6:0] next_ptr;
  logic [7:0] tx_reload;

  assign rx_byte = {rx_shift[6:0], sda};
  assign byte_done = scl_fall && (bit_count == CFB_BITS_PER_BYTE);

  always_comb begin
    next_tx_byte = '0;
    if (!byte_mode) begin
      next_tx_byte = CFB_BLOCK_COUNT;
    end else if (byte_ptr < CFB_OFFSET_LIMIT) begin
      next_tx_byte = enable_reg[byte_ptr[1:0]];
    end
  end

  // Byte that follows an acknowledged transmit byte
  assign next_ptr = count_pending ? byte_ptr : byte_ptr + 7'h01;
  assign tx_reload = (next_ptr < CFB_OFFSET_LIMIT) ? enable_reg[next_ptr[1:0]] : 8'h00;

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state <= LINK_IDLE;
      bit_count <= '0;
      rx_shift <= '0;
      tx_shift <= '0;
      byte_ptr <= CFB_FIRST_OFFSET;
      read_dir <= 1'b0;
      byte_mode <= 1'b0;
      count_pending <= 1'b0;
      master_ack <= 1'b0;
      sda_drive <= 1'b0;
    end else if (bus_start) begin
      state <= LINK_ADDR;
      bit_count <= '0;
      sda_drive <= 1'b0;
    end else if (bus_stop) begin
      state <= LINK_IDLE;
      sda_drive <= 1'b0;
    end else begin
      case (state)
        LINK_IDLE: begin
          sda_drive <= 1'b0;
        end
        LINK_ADDR: begin
          if (scl_rise) begin
            rx_shift <= rx_byte; // R7
            bit_count <= bit_count + 4'h1;
          end else if (byte_done) begin
            if ((rx_shift[7:1] == CFB_SLAVE_ADDR[7:1]) && port_en_link) begin // R10
              read_dir <= rx_shift[0];
              sda_drive <= 1'b1;
              state <= LINK_ADDR_ACK;
            end else begin
              state <= LINK_SKIP;
            end
          end
        end
        LINK_ADDR_ACK: begin
          if (scl_fall) begin
            bit_count <= '0;
            if (read_dir) begin
              count_pending <= ~byte_mode;
              tx_shift <= next_tx_byte;
              sda_drive <= ~next_tx_byte[7];
              if (!byte_mode) begin
                byte_ptr <= CFB_FIRST_OFFSET; // R12
              end
              state <= LINK_TX;
            end else begin
              sda_drive <= 1'b0;
              state <= LINK_CMD;
            end
          end
        end
        LINK_CMD: begin
          if (scl_rise) begin
            rx_shift <= rx_byte;
            bit_count <= bit_count + 4'h1;
          end else if (byte_done) begin
            byte_mode <= rx_shift[CFB_CMD_BYTE_MODE_BIT]; // R11
            byte_ptr <= rx_shift[CFB_CMD_BYTE_MODE_BIT] ? rx_shift[6:0]
                                                         : CFB_FIRST_OFFSET; // R11
            sda_drive <= 1'b1;
            state <= LINK_CMD_ACK;
          end
        end
        LINK_CMD_ACK: begin
          if (scl_fall) begin
            sda_drive <= 1'b0;
            bit_count <= '0;
            state <= byte_mode ? LINK_WDATA : LINK_COUNT;
          end
        end
        LINK_COUNT: begin
          if (scl_rise) begin
            rx_shift <= rx_byte;
            bit_count <= bit_count + 4'h1;
          end else if (byte_done) begin
            sda_drive <= 1'b1;
            state <= LINK_COUNT_ACK;
          end
        end
        LINK_COUNT_ACK: begin
          if (scl_fall) begin
            sda_drive <= 1'b0;
            bit_count <= '0;
            state <= LINK_WDATA;
          end
        end
        LINK_WDATA: begin
          if (scl_rise) begin
            rx_shift <= rx_byte; // R7
            bit_count <= bit_count + 4'h1;
          end else if (byte_done) begin
            sda_drive <= 1'b1;
            state <= LINK_WDATA_ACK;
          end
        end
        LINK_WDATA_ACK: begin
          if (scl_fall) begin
            sda_drive <= 1'b0;
            bit_count <= '0;
            byte_ptr <= byte_ptr + 7'h01; // R12
            state <= LINK_WDATA;
          end
        end
        LINK_TX: begin
          if (scl_fall) begin
            if (bit_count == CFB_LAST_BIT) begin
              sda_drive <= 1'b0;
              state <= LINK_TX_ACK;
            end else begin
              sda_drive <= ~tx_shift[6]; // R12
              tx_shift <= {tx_shift[6:0], 1'b0};
              bit_count <= bit_count + 4'h1;
            end
          end
        end
        LINK_TX_ACK: begin
          if (scl_rise) begin
            master_ack <= ~sda;
          end else if (scl_fall) begin
            bit_count <= '0;
            if (master_ack) begin
              count_pending <= 1'b0;
              byte_ptr <= next_ptr; // R12
              tx_shift <= tx_reload; // R12
              sda_drive <= ~tx_reload[7];
              state <= LINK_TX;
            end else begin
              state <= LINK_SKIP;
            end
          end
        end
        LINK_SKIP: begin
          sda_drive <= 1'b0;
        end
        default: begin
          state <= LINK_IDLE;
          sda_drive <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain data: only ever pulls low
  assign serial_data_out = 1'b0;
  assign serial_data_oe = sda_drive;

  // ==========================================================================
  // Enable registers, written at the end of each data byte
  assign write_strobe = (state == LINK_WDATA) && byte_done && !bus_start && !bus_stop;

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      for (int i = 0; i < CFB_ENABLE_BYTES; i++) begin
        enable_reg[i] <= CFB_ENABLE_RESET; // R6 R13
      end
    end else if (write_strobe && (byte_ptr < CFB_OFFSET_LIMIT)) begin
      enable_reg[byte_ptr[1:0]] <= rx_shift; // R7 R4
    end
  end

  // ==========================================================================
  // Enable snapshot crossing to pclk by toggle handshake
  logic snap_toggle;
  logic snap_toggle_p;
  logic snap_toggle_d;
  logic [23:0] enable_mirror;

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      snap_toggle <= 1'b0;
    end else if (write_strobe) begin
      snap_toggle <= ~snap_toggle;
    end
  end

  cfb_sync #(.WIDTH(1)) u_snap_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(snap_toggle),
    .q(snap_toggle_p)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_toggle_d <= 1'b0;
      enable_mirror <= {CFB_ENABLE_RESET, CFB_ENABLE_RESET, CFB_ENABLE_RESET};
    end else begin
      snap_toggle_d <= snap_toggle_p;
      if (snap_toggle_p != snap_toggle_d) begin
        enable_mirror <= {enable_reg[2], enable_reg[1], enable_reg[0]};
      end
    end
  end

  // ==========================================================================
  // Mode pin seen by software
  logic mode_p;

  cfb_sync #(.WIDTH(1)) u_mode_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(bank_mode_select),
    .q(mode_p)
  );

  // ==========================================================================
  // APB slave
  logic apb_setup;
  logic apb_access;
  logic addr_hit;

  assign apb_setup = psel && !penable;
  assign apb_access = psel && penable;
  assign addr_hit = (paddr == CFB_CTRL_OFFSET) || (paddr == CFB_STATUS_OFFSET)
                    || (paddr == CFB_ENABLES_OFFSET);
  assign pready = 1'b1;
  assign pslverr = apb_access && !addr_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_en <= CFB_CTRL_PORT_EN_RESET;
    end else if (apb_access && pwrite && (paddr == CFB_CTRL_OFFSET)) begin
      port_en <= pwdata[CFB_CTRL_PORT_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (apb_setup && !pwrite) begin
      prdata <= '0;
      case (paddr)
        CFB_CTRL_OFFSET: prdata[CFB_CTRL_PORT_EN_BIT] <= port_en;
        CFB_STATUS_OFFSET: prdata[CFB_STATUS_MODE_BIT] <= mode_p;
        CFB_ENABLES_OFFSET: prdata[23:0] <= enable_mirror;
        default: prdata <= '0;
      endcase
    end
  end

  // ==========================================================================
  // Output gating
  logic pair_bank;
  logic [CFB_PAIR_COUNT-1:0] pair_en;
  logic [CFB_SINGLE_COUNT-1:0] single_en;

  assign pair_bank = (bank_mode_select == MODE_PAIR_BANK); // R1 R2
  assign pair_en = enable_reg[CFB_PAIR_BYTE][CFB_PAIR_COUNT-1:0];
  assign single_en = {enable_reg[CFB_SINGLE_HI_BYTE][CFB_SINGLE_COUNT-CFB_SINGLE_LO_COUNT-1:0],
                      enable_reg[CFB_SINGLE_LO_BYTE]};

  always_comb begin
    for (int i = 0; i < CFB_PAIR_COUNT; i++) begin
      pair_true_outputs[i] = pair_bank & pair_en[i] & reference_clock_in; // R3 R4
      pair_complement_outputs[i] = pair_bank & pair_en[i] & ~reference_clock_in; // R3 R4
    end
    for (int j = 0; j < CFB_SINGLE_COUNT; j++) begin
      single_outputs[j] = ~pair_bank & single_en[j] & reference_clock_in; // R1 R4
    end
  end

  assign pair_feedback_out = pair_bank & reference_clock_in; // R5 R8
  assign single_feedback_out = ~pair_bank & reference_clock_in; // R5 R8

endmodule

`default_nettype wire

// file: test/cfb_props.sv
`timescale 1ns/1ps
`default_nettype none

// ====
// Output gating, serial drive timing and APB answers
module cfb_props
  import cfb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic link_clk,
  input wire logic serial_clock_in,
  input wire logic serial_data_oe,
  input wire logic bank_mode_select,
  input wire logic reference_clock_in,
  input wire logic [CFB_PAIR_COUNT-1:0] pair_true_outputs,
  input wire logic [CFB_PAIR_COUNT-1:0] pair_complement_outputs,
  input wire logic [CFB_SINGLE_COUNT-1:0] single_outputs,
  input wire logic pair_feedback_out,
  input wire logic single_feedback_out
);
  logic m;
  logic r;
  logic mapped;
  assign m = bank_mode_select;
  assign r = reference_clock_in;
  assign mapped = paddr == CFB_CTRL_OFFSET || paddr == CFB_STATUS_OFFSET
    || paddr == CFB_ENABLES_OFFSET;

  chk_pair_true_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (pair_true_outputs & ~{CFB_PAIR_COUNT{m & r}}) == '0) else $error("pair true off phase");
  chk_pair_comp_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (pair_complement_outputs & ~{CFB_PAIR_COUNT{m & ~r}}) == '0) else $error("complement off");
  chk_pair_bank_off: assert property (@(posedge pclk) disable iff (!presetn)
    !m |-> pair_true_outputs == '0 && pair_complement_outputs == '0 && !pair_feedback_out)
    else $error("pair bank runs in single mode");
  chk_single_bank_off: assert property (@(posedge pclk) disable iff (!presetn)
    m |-> single_outputs == '0 && !single_feedback_out) else $error("single bank runs");
  chk_single_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (single_outputs & ~{CFB_SINGLE_COUNT{~m & r}}) == '0) else $error("single off phase");
  chk_feedback_free: assert property (@(posedge pclk) disable iff (!presetn)
    pair_feedback_out == (m & r) && single_feedback_out == (~m & r)) else $error("feedback");
  chk_oe_scl_low: assert property (@(posedge link_clk) disable iff (!presetn)
    $changed(serial_data_oe) |-> !serial_clock_in) else $error("data moved with clock high");
  chk_apb_error: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable |-> pslverr == !mapped) else $error("pslverr wrong");
  chk_prdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(psel && !penable) |-> $stable(prdata)) else $error("prdata moved");
  chk_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && !mapped |-> prdata == '0) else $error("unmapped data");
endmodule

bind cfb_clock_fanout cfb_props cfb_props_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pslverr(pslverr),
  .link_clk(link_clk), .serial_clock_in(serial_clock_in), .serial_data_oe(serial_data_oe),
  .bank_mode_select(bank_mode_select), .reference_clock_in(reference_clock_in),
  .pair_true_outputs(pair_true_outputs), .pair_complement_outputs(pair_complement_outputs),
  .single_outputs(single_outputs), .pair_feedback_out(pair_feedback_out),
  .single_feedback_out(single_feedback_out));

`default_nettype wire

// file: test/cfb_smbus_host.sv
`timescale 1ns/1ps
`default_nettype none

// ====
// Two-wire host; data line pulled up, clock driven directly by the host, stands high between frames
module cfb_smbus_host (
  input wire logic link_clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_low <= ~b;
    tick(5);
    scl <= 1'b1;
    tick(5);
    s = sda_wire;
    tick(5);
    scl <= 1'b0;
    tick(5);
  endtask
  task automatic start;
    sda_low <= 1'b0;
    tick(5);
    scl <= 1'b1;
    tick(10);
    sda_low <= 1'b1;
    tick(10);
    scl <= 1'b0;
    tick(5);
  endtask
  task automatic stop;
    sda_low <= 1'b1;
    tick(5);
    scl <= 1'b1;
    tick(10);
    sda_low <= 1'b0;
    tick(10);
  endtask
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q,
                         output logic s);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, s);
  endtask
  // Writes nw bytes from byte 0 up, then reads nr bytes after a repeated start
  task automatic frame(input logic [7:0] adr, cmd, input int nw, input logic [31:0] wd,
                       input int nr, output logic [31:0] rd, output logic ok);
    logic [7:0] q;
    logic s;
    ok = 1'b1;
    rd = '0;
    start;
    byte_io(adr, 1'b1, q, s);
    ok &= ~s;
    byte_io(cmd, 1'b1, q, s);
    ok &= ~s;
    for (int k = 0; k < nw; k++) begin
      byte_io(wd[8*k +: 8], 1'b1, q, s);
      ok &= ~s;
    end
    if (nr > 0) begin
      start;
      byte_io(adr | 8'h01, 1'b1, q, s);
      ok &= ~s;
      for (int k = 0; k < nr; k++) begin
        byte_io(8'hFF, k == nr - 1, q, s);
        rd[8*k +: 8] = q;
      end
    end
    stop;
  endtask
endmodule

`default_nettype wire

// file: test/test_clock_fanout_mode_and_enable.sv
`timescale 1ns/1ps
`default_nettype none

// ====
// Register, serial and clock output sequences
module test_clock_fanout_mode_and_enable
  import cfb_pkg::*;
;
  logic pclk = 1'b0;
  logic link_clk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic mode = 1'b1;
  logic ref_clk = 1'b0;
  logic [31:0] prdata, sd;
  logic pready, pslverr, sdo, sda_oe, scl, sda_low, sok, fbp, fbs;
  logic [5:0] pt, pc;
  logic [12:0] so;
  wire logic sda;
  int n_fail = 0;
  int checked = 0;
  assign sda = ~(sda_low | sda_oe);

  always #20 pclk = ~pclk;
  initial begin
    #3.3;
    forever #6 link_clk = ~link_clk;
  end
  always @(posedge pclk) ref_clk <= ~ref_clk;

  cfb_clock_fanout cfb_clock_fanout_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_clk(link_clk), .serial_clock_in(scl),
    .serial_data_in(sda), .serial_data_out(sdo), .serial_data_oe(sda_oe),
    .bank_mode_select(mode), .reference_clock_in(ref_clk), .pair_true_outputs(pt),
    .pair_complement_outputs(pc), .single_outputs(so), .pair_feedback_out(fbp),
    .single_feedback_out(fbs));
  cfb_smbus_host cfb_smbus_host_i (.link_clk(link_clk), .sda_wire(sda), .scl(scl),
    .sda_low(sda_low));

  task automatic chk(input string what, input logic [31:0] exp, got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb_chk(input logic wr, input logic [7:0] a, input logic [31:0] wd, exp,
                         input logic eerr, input string what);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h1, {31'h0, pready});
    if (!wr) chk(what, exp, prdata);
    chk("pslverr", {31'h0, eerr}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic sm(input logic [7:0] a, c, input int nw, input logic [31:0] wd,
                    input int nr);
    cfb_smbus_host_i.frame(a, c, nw, wd, nr, sd, sok);
    repeat (10) @(posedge pclk);
  endtask
  task automatic outs(input logic m, input logic [5:0] ep, input logic [12:0] es);
    logic r;
    @(posedge pclk);
    mode <= m;
    repeat (2) begin
      @(posedge pclk);
      #1;
      r = ref_clk;
      chk("clock outputs", {(m ? ep & {6{r}} : 6'h00), (m ? ep & {6{~r}} : 6'h00),
          (m ? 13'h0000 : es & {13{r}}), m & r, ~m & r}, {pt, pc, so, fbp, fbs});
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #200_000;
    n_fail++;
    stop_test;
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb_chk(0, CFB_ENABLES_OFFSET, 0, 32'h00FFFFFF, 0, "enables");
    apb_chk(0, CFB_CTRL_OFFSET, 0, 32'h1, 0, "ctrl");
    apb_chk(0, CFB_STATUS_OFFSET, 0, 32'h1, 0, "status");
    apb_chk(0, 8'h0C, 0, 32'h0, 1, "unmapped");
    apb_chk(1, 8'h0C, 32'hFFFFFFFF, 0, 1, "unmapped");
    apb_chk(1, CFB_ENABLES_OFFSET, 32'h0, 0, 0, "enables");
    outs(1, 6'h3F, 13'h1FFF);
    outs(0, 6'h3F, 13'h1FFF);
    sm(CFB_SLAVE_ADDR, 8'h00, 4, 32'h0AA51503, 0);
    chk("block write ack", 32'h1, {31'h0, sok});
    apb_chk(0, CFB_ENABLES_OFFSET, 0, 32'h000AA515, 0, "enables");
    outs(1, 6'h15, 13'h0000);
    outs(0, 6'h00, 13'h0AA5);
    sm(CFB_SLAVE_ADDR, 8'h00, 0, 0, 4);
    chk("block read", 32'h0AA51503, sd);
    sm(CFB_SLAVE_ADDR, 8'h81, 1, 32'h3C, 0);
    sm(CFB_SLAVE_ADDR, 8'h82, 0, 0, 1);
    chk("byte read", 32'h0A, sd);
    apb_chk(0, CFB_ENABLES_OFFSET, 0, 32'h000A3C15, 0, "enables");
    sm(8'hD4, 8'h80, 1, 32'h00, 0);
    chk("foreign address ack", 32'h0, {31'h0, sok});
    apb_chk(1, CFB_CTRL_OFFSET, 32'h0, 0, 0, "ctrl");
    sm(CFB_SLAVE_ADDR, 8'h80, 1, 32'h00, 0);
    chk("disabled port ack", 32'h0, {31'h0, sok});
    apb_chk(1, CFB_CTRL_OFFSET, 32'h1, 0, 0, "ctrl");
    apb_chk(0, CFB_ENABLES_OFFSET, 0, 32'h000A3C15, 0, "enables");
    sm(CFB_SLAVE_ADDR, 8'h80, 1, 32'h00, 0);
    chk("re-enabled port ack", 32'h1, {31'h0, sok});
    chk("data pin level", 32'h0, {31'h0, sdo});
    outs(1, 6'h00, 13'h0000);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb_chk(0, CFB_ENABLES_OFFSET, 0, 32'h00FFFFFF, 0, "enables");
    stop_test;
  end
endmodule

`default_nettype wire
